// ===== src/can_timing_pkg.sv
// constants shared by the bit timing and receiver flag logic
package can_timing_pkg;

  // ==========================================================
  // register map, index on the plain register port
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_FIRST_CTRL = 3'h0;
  localparam logic [2:0] OFS_SECOND_CTRL = 3'h1;
  localparam logic [2:0] OFS_JUMP_PRESCALE = 3'h2;
  localparam logic [2:0] OFS_SEG_SAMPLING = 3'h3;
  localparam logic [2:0] OFS_RX_FLAGS = 3'h4;
  localparam logic [2:0] OFS_RX_ENABLES = 3'h5;

  // ==========================================================
  // field positions
  localparam int SOFT_RESET_BIT = 0;
  localparam int SYNCED_BIT = 4;
  localparam int JUMP_LSB = 6;
  localparam int PRESCALE_LSB = 0;
  localparam int TRIPLE_BIT = 7;
  localparam int SEG2_LSB = 4;
  localparam int SEG1_LSB = 0;
  localparam int WAKEUP_BIT = 7;
  localparam int RX_WARN_BIT = 6;
  localparam int TX_WARN_BIT = 5;
  localparam int RX_PASSIVE_BIT = 4;
  localparam int TX_PASSIVE_BIT = 3;
  localparam int BUS_OFF_BIT = 2;
  localparam int OVERRUN_BIT = 1;
  localparam int RX_FULL_BIT = 0;

  // ==========================================================
  // values after reset
  localparam logic [7:0] FIRST_CTRL_RESET = 8'h01;
  localparam logic [7:0] SECOND_CTRL_RESET = 8'h00;
  localparam logic [7:0] JUMP_PRESCALE_RESET = 8'h00;
  localparam logic [7:0] SEG_SAMPLING_RESET = 8'h00;
  localparam logic [7:0] RX_FLAGS_RESET = 8'h00;
  localparam logic [7:0] RX_ENABLES_RESET = 8'h00;

  // ==========================================================
  // error counter thresholds and bus-off recovery counts
  localparam logic [8:0] WARN_LEVEL = 9'h060;
  localparam logic [8:0] RX_PASSIVE_LEVEL = 9'h07f;
  localparam logic [8:0] TX_PASSIVE_LEVEL = 9'h080;
  localparam logic [8:0] COUNT_MAX = 9'h0ff;
  localparam logic [3:0] IDLE_RECESSIVE_BITS = 4'hb;
  localparam logic [7:0] RECOVERY_SEQUENCES = 8'h80;

  // ==========================================================
  // bit timing state
  typedef enum logic [1:0] {SYNC_SEG, PHASE1, PHASE2} bit_phase_e;

endpackage : can_timing_pkg

// ===== src/can_bit_timer.sv
// quantum prescaler, bit segment sequencer and bus sampler
`timescale 1ns/1ns
`default_nettype none

module can_bit_timer
  import can_timing_pkg::*;
#(
  parameter int PRESCALE_W = 6
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic rx_level,
  input wire logic [1:0] resync_jump_width,
  input wire logic [PRESCALE_W-1:0] quantum_prescaler,
  input wire logic triple_sample_select,
  input wire logic [3:0] first_time_segment,
  input wire logic [2:0] second_time_segment,
  output logic sample_valid,
  output logic sampled_bit
);

  // ==========================================================
  // elaboration check
  if (PRESCALE_W < 1 || PRESCALE_W > 16)
  begin : bad_width
    $error("prescaler width out of range");
  end

  logic [PRESCALE_W-1:0] div_cnt;
  bit_phase_e phase;
  logic [4:0] pos;
  logic [2:0] stretch;
  logic resynced;
  logic edge_seen;
  logic rx_prev;
  logic [1:0] hist;

  // ==========================================================
  // decoded lengths, in quanta
  wire logic tq_tick = (div_cnt == quantum_prescaler);
  wire logic [2:0] jump_len = {1'b0, resync_jump_width} + 3'h1;
  wire logic [4:0] seg1_len = {1'b0, first_time_segment} + 5'h01;
  wire logic [4:0] seg2_len = {2'b00, second_time_segment} + 5'h01;
  wire logic [4:0] pos_next = pos + 5'h01;
  wire logic [4:0] seg1_end = seg1_len + {2'b00, stretch};
  wire logic [4:0] seg2_left = seg2_len - pos_next;
  wire logic fall = rx_prev & ~rx_level;
  wire logic [4:0] late_stretch =
    (pos_next < {2'b00, jump_len}) ? pos_next : {2'b00, jump_len};
  wire logic majority = (hist[1] & hist[0]) | (hist[1] & rx_level)
    | (hist[0] & rx_level);
  wire logic bus_value = triple_sample_select ? majority : rx_level;

  // ==========================================================
  // quantum divider: divisor is the prescaler field plus one
  always_ff @(posedge clk)
  begin
    if (rst || !run || tq_tick)
      div_cnt <= '0;
    else
      div_cnt <= div_cnt + 1'b1;
  end

  // ==========================================================
  // edge catcher, held until the next quantum boundary
  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      rx_prev <= 1'b1;
      edge_seen <= 1'b0;
    end
    else
    begin
      rx_prev <= rx_level;
      edge_seen <= tq_tick ? fall : (edge_seen | fall);
    end
  end

  // ==========================================================
  // bit = sync quantum + segment one + segment two, with resync
  always_ff @(posedge clk)
  begin
    if (rst || !run)
    begin
      phase <= SYNC_SEG;
      pos <= 5'h00;
      stretch <= 3'h0;
      resynced <= 1'b0;
      hist <= 2'b11;
      sample_valid <= 1'b0;
      sampled_bit <= 1'b1;
    end
    else
    begin
      sample_valid <= 1'b0;
      if (tq_tick)
      begin
        hist <= {hist[0], rx_level};
        case (phase)
          SYNC_SEG:
          begin
            phase <= PHASE1;
            pos <= 5'h00;
            stretch <= 3'h0;
            resynced <= 1'b0;
          end
          PHASE1:
          begin
            // late edge lengthens segment one by at most the jump width
            if (edge_seen && !resynced)
            begin
              stretch <= late_stretch[2:0];
              resynced <= 1'b1;
              pos <= pos_next;
            end
            else if (pos_next >= seg1_end)
            begin
              phase <= PHASE2;
              pos <= 5'h00;
              sample_valid <= 1'b1;
              sampled_bit <= bus_value;
            end
            else
              pos <= pos_next;
          end
          PHASE2:
          begin
            // early edge shortens segment two by at most the jump width
            if (edge_seen && !resynced
              && seg2_left <= {2'b00, jump_len})
            begin
              phase <= PHASE1;
              pos <= 5'h00;
              stretch <= 3'h0;
              resynced <= 1'b1;
            end
            else if (pos_next >= seg2_len)
            begin
              phase <= SYNC_SEG;
              pos <= 5'h00;
            end
            else
              pos <= pos_next;
          end
          default:
          begin
            phase <= SYNC_SEG;
            pos <= 5'h00;
          end
        endcase
      end
    end
  end

endmodule : can_bit_timer

`default_nettype wire

// ===== src/can_bit_timing_rx_flags.sv
// bit timing configuration and receiver event flags of a CAN controller
//
// How it works
// - jump width code 0..3 allows 1..4 quanta of resynchronisation
// - quantum clock is module clock divided by prescaler field plus one
// - jump/prescale register is written only while soft reset is set
// - segment/sampling register is written only while soft reset is set
// - second control register is written only while soft reset is set
// - triple mode takes majority of three samples, else one sample
// - segment one lasts field plus one quanta; 1 to 3 are invalid
// - segment two lasts field plus one quanta; one quantum is invalid
// - writing one clears a flag once its cause is gone; zero is ignored
// - hard or soft reset clears the flags; held clear during soft reset
// - bus activity while asleep sets wakeup, interrupt if enabled
// - receive count at 96 sets receive warning unless passive or off
// - transmit count at 96 sets transmit warning unless passive or off
// - receive count 127..255 sets receive passive unless bus-off
// - transmit count 128..255 sets transmit passive unless bus-off
// - transmit count over 255 sets bus-off; clear waits 128 x 11 idle
// - receive overrun sets the overrun flag until cleared
// - good message sets receive full; no buffer exchange while set
// - soft reset aborts traffic and loses sync, counters untouched
`timescale 1ns/1ns
`default_nettype none

module can_bit_timing_rx_flags
  import can_timing_pkg::*;
#(
  parameter int PRESCALE_W = 6
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic can_rx,
  input wire logic sleep_mode,
  input wire logic [7:0] receive_error_count,
  input wire logic [8:0] transmit_error_count,
  input wire logic rx_overrun,
  input wire logic rx_message_ok,
  output logic buffer_exchange,
  output logic wakeup_irq,
  output logic error_irq,
  output logic receive_irq,
  output logic soft_reset_active,
  output logic bus_synchronized,
  output logic bus_off_state
);

  // ==========================================================
  // elaboration check: the prescale field is six bits wide
  if (PRESCALE_W != 6)
  begin : bad_prescale
    $error("prescaler field must be six bits");
  end

  // software visible registers
  logic [7:0] first_module_control;
  logic [7:0] second_module_control;
  logic [7:0] bus_timing_jump_prescale;
  logic [7:0] bus_timing_segments_sampling;
  logic [7:0] receiver_event_flags;
  logic [7:0] receiver_interrupt_enables;

  // synchroniser stages, settled level
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic rx_level;
  logic rx_level_prev;

  // recessive run length, runs completed
  logic [3:0] idle_run;
  logic [7:0] idle_seqs;

  // bit samples from the timer
  logic sample_valid;
  logic sampled_bit;

  // flag value for the next edge
  logic [7:0] next_flags;

  // ==========================================================
  // address decode and write qualification
  wire logic soft_reset_control = first_module_control[SOFT_RESET_BIT];
  wire logic hit_first = (reg_addr == OFS_FIRST_CTRL);
  wire logic hit_second = (reg_addr == OFS_SECOND_CTRL);
  wire logic hit_jump = (reg_addr == OFS_JUMP_PRESCALE);
  wire logic hit_seg = (reg_addr == OFS_SEG_SAMPLING);
  wire logic hit_flags = (reg_addr == OFS_RX_FLAGS);
  wire logic hit_enables = (reg_addr == OFS_RX_ENABLES);

  // soft reset bit stays writable
  wire logic wr_first = reg_write & hit_first;
  wire logic wr_second = reg_write & hit_second & soft_reset_control;
  wire logic wr_jump = reg_write & hit_jump & soft_reset_control;
  wire logic wr_seg = reg_write & hit_seg & soft_reset_control;
  wire logic wr_flags = reg_write & hit_flags;
  wire logic wr_enables = reg_write & hit_enables;

  // ==========================================================
  // timing fields
  wire logic [1:0] resync_jump_width =
    bus_timing_jump_prescale[JUMP_LSB +: 2];
  wire logic [PRESCALE_W-1:0] quantum_prescaler =
    bus_timing_jump_prescale[PRESCALE_LSB +: PRESCALE_W];

  // sampling and segment fields
  wire logic triple_sample_select =
    bus_timing_segments_sampling[TRIPLE_BIT];
  wire logic [2:0] second_time_segment =
    bus_timing_segments_sampling[SEG2_LSB +: 3];
  wire logic [3:0] first_time_segment =
    bus_timing_segments_sampling[SEG1_LSB +: 4];

  // ==========================================================
  // current flag values by name
  wire logic wakeup_flag = receiver_event_flags[WAKEUP_BIT];
  wire logic rx_warning_flag = receiver_event_flags[RX_WARN_BIT];
  wire logic tx_warning_flag = receiver_event_flags[TX_WARN_BIT];
  wire logic rx_error_passive_flag = receiver_event_flags[RX_PASSIVE_BIT];
  wire logic tx_error_passive_flag = receiver_event_flags[TX_PASSIVE_BIT];
  wire logic bus_off_flag = receiver_event_flags[BUS_OFF_BIT];
  wire logic overrun_flag = receiver_event_flags[OVERRUN_BIT];
  wire logic receive_full_flag = receiver_event_flags[RX_FULL_BIT];

  // ==========================================================
  // setting conditions of each flag
  wire logic [8:0] rec_wide = {1'b0, receive_error_count};
  wire logic quiet = ~rx_error_passive_flag & ~tx_error_passive_flag
    & ~bus_off_flag;
  wire logic rx_warn_cond = (rec_wide >= WARN_LEVEL) & quiet;
  wire logic tx_warn_cond = (transmit_error_count >= WARN_LEVEL)
    & quiet;

  // upper bounds matter once bus-off
  wire logic rx_passive_cond = (rec_wide >= RX_PASSIVE_LEVEL)
    & (rec_wide <= COUNT_MAX) & ~bus_off_flag;
  wire logic tx_passive_cond = (transmit_error_count >= TX_PASSIVE_LEVEL)
    & (transmit_error_count <= COUNT_MAX) & ~bus_off_flag;
  wire logic bus_off_cond = (transmit_error_count > COUNT_MAX);

  // wakeup on any falling edge of the glitch-filtered level
  wire logic bus_activity = rx_level_prev & ~rx_level;
  wire logic wakeup_cond = sleep_mode & bus_activity;
  // a message landing on a full buffer is lost: count it as overrun
  wire logic exchange_ok = rx_message_ok & ~receive_full_flag;
  wire logic overrun_cond = rx_overrun
    | (rx_message_ok & receive_full_flag);

  // events as one vector, and the still-holding causes that block clears
  wire logic [7:0] set_vec = {wakeup_cond, rx_warn_cond, tx_warn_cond,
    rx_passive_cond, tx_passive_cond, bus_off_cond, overrun_cond,
    exchange_ok};
  wire logic [7:0] hold_vec = {wakeup_cond, rx_warn_cond, tx_warn_cond,
    rx_passive_cond, tx_passive_cond, bus_off_state | bus_off_cond,
    overrun_cond, exchange_ok};
  wire logic [7:0] clear_vec = (wr_flags ? reg_wdata : 8'h00)
    & ~hold_vec;

  // ==========================================================
  // idle recessive tracking on sampled bits
  wire logic idle_bit = sample_valid & sampled_bit;
  wire logic run_done = idle_bit & (idle_run == IDLE_RECESSIVE_BITS - 4'h1);
  wire logic [7:0] idle_seqs_next = idle_seqs + 8'h01;

  // last run of the last sequence
  wire logic recovered = run_done & bus_off_state
    & (idle_seqs_next == RECOVERY_SEQUENCES);

  // ==========================================================
  // read selection; unmapped addresses read as zero
  wire logic [7:0] first_view = {first_module_control[7:SYNCED_BIT+1],
    bus_synchronized, first_module_control[SYNCED_BIT-1:0]};

  // index order
  wire logic [7:0] read_mux =
    hit_first ? first_view :
    hit_second ? second_module_control :
    hit_jump ? bus_timing_jump_prescale :
    hit_seg ? bus_timing_segments_sampling :
    hit_flags ? receiver_event_flags :
    hit_enables ? receiver_interrupt_enables : 8'h00;

  // ==========================================================
  // pin synchroniser: the level moves once stages two and three agree
  // stage one may be metastable: only stage two reads it
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_level <= 1'b1;
      rx_level_prev <= 1'b1;
    end
    else
    begin
      rx_s1 <= can_rx;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      rx_level_prev <= rx_level;
      // agreement filters one-cycle glitches
      if (rx_s2 == rx_s3)
        rx_level <= rx_s3;
    end
  end

  // ==========================================================
  // control registers; soft reset bit always writable
  // the synced bit is status, never stored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      first_module_control <= FIRST_CTRL_RESET;
      second_module_control <= SECOND_CTRL_RESET;
      bus_timing_jump_prescale <= JUMP_PRESCALE_RESET;
      bus_timing_segments_sampling <= SEG_SAMPLING_RESET;
    end
    else
    begin
      if (wr_first)
        first_module_control <= {reg_wdata[7:SYNCED_BIT+1], 1'b0,
          reg_wdata[SYNCED_BIT-1:0]};
      if (wr_second)
        second_module_control <= reg_wdata;
      if (wr_jump)
        bus_timing_jump_prescale <= reg_wdata;
      if (wr_seg)
        bus_timing_segments_sampling <= reg_wdata;
    end
  end

  // ==========================================================
  // flag update: a set in the same cycle beats a clear
  // a held cause blocks its clear
  always_comb
  begin
    next_flags = (receiver_event_flags & ~clear_vec) | set_vec;
  end

  // flags and enables sit at reset value while soft reset is held
  always_ff @(posedge clk)
  begin
    if (rst || soft_reset_control)
    begin
      receiver_event_flags <= RX_FLAGS_RESET;
      receiver_interrupt_enables <= RX_ENABLES_RESET;
    end
    else
    begin
      receiver_event_flags <= next_flags;
      if (wr_enables)
        receiver_interrupt_enables <= reg_wdata;
    end
  end

  // ==========================================================
  // bus-off state and idle sequence counting
  // counters run only out of soft reset, so sync restarts on release
  always_ff @(posedge clk)
  begin
    if (rst)
      bus_off_state <= 1'b0;
    else if (bus_off_cond)
      bus_off_state <= 1'b1;
    else if (recovered)
      bus_off_state <= 1'b0;
  end

  // bus-off outlives soft reset; runs restart
  always_ff @(posedge clk)
  begin
    if (rst || soft_reset_control)
    begin
      idle_run <= 4'h0;
      idle_seqs <= 8'h00;
      bus_synchronized <= 1'b0;
    end
    else if (sample_valid)
    begin
      // a dominant sample breaks the run
      idle_run <= (!sampled_bit || run_done) ? 4'h0 : idle_run + 4'h1;
      if (run_done && !bus_off_state)
        bus_synchronized <= 1'b1;
      if (run_done && bus_off_state)
        idle_seqs <= recovered ? 8'h00 : idle_seqs_next;
      else if (!bus_off_state)
        idle_seqs <= 8'h00;
    end
  end

  // ==========================================================
  // registered outputs and interrupt requests
  // irqs lag their flag by one cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      reg_rdata <= 8'h00;
      buffer_exchange <= 1'b0;
      wakeup_irq <= 1'b0;
      error_irq <= 1'b0;
      receive_irq <= 1'b0;
      soft_reset_active <= 1'b1;
    end
    else
    begin
      reg_rdata <= reg_read ? read_mux : 8'h00;
      buffer_exchange <= exchange_ok & ~soft_reset_control;
      // masks: bit 7 wakeup, bits 6..1 errors
      wakeup_irq <= |(receiver_event_flags & receiver_interrupt_enables
        & 8'h80);
      error_irq <= |(receiver_event_flags & receiver_interrupt_enables
        & 8'h7e);
      receive_irq <= receive_full_flag
        & receiver_interrupt_enables[RX_FULL_BIT];
      soft_reset_active <= soft_reset_control;
    end
  end

  // ==========================================================
  // bit timing engine, halted and unsynchronised in soft reset
  // a new bit starts on release
  can_bit_timer #(
    .PRESCALE_W(PRESCALE_W)
  ) timer (
    .clk(clk),
    .rst(rst),
    .run(~soft_reset_control),
    .rx_level(rx_level),
    .resync_jump_width(resync_jump_width),
    .quantum_prescaler(quantum_prescaler),
    .triple_sample_select(triple_sample_select),
    .first_time_segment(first_time_segment),
    .second_time_segment(second_time_segment),
    .sample_valid(sample_valid),
    .sampled_bit(sampled_bit)
  );

endmodule : can_bit_timing_rx_flags

`default_nettype wire

// ===== test/can_bus_node.sv
// far-side bus node: idles recessive, sends dominant bursts
`timescale 1ns/1ns
`default_nettype none

module can_bus_node (
  input wire logic clk,
  input wire logic start,
  input wire logic [7:0] dom_len,
  output logic can_rx
);
  // ====
  // burst length counter
  logic [7:0] left = 8'h00;

  // the bus returns to recessive, its pulled-up level, after a burst
  always @(posedge clk)
  begin
    if (start)
      left <= dom_len;
    else if (left != 8'h00)
      left <= left - 8'h01;
  end
  assign can_rx = (left == 8'h00);
endmodule : can_bus_node
`default_nettype wire

// ===== test/can_bit_timing_rx_flags_checker.sv
// port assertions for the bit timing and receiver flag block
`timescale 1ns/1ns
`default_nettype none

module can_bit_timing_rx_flags_checker
  import can_timing_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic sleep_mode,
  input wire logic [8:0] transmit_error_count,
  input wire logic rx_message_ok,
  input wire logic buffer_exchange,
  input wire logic wakeup_irq,
  input wire logic error_irq,
  input wire logic receive_irq,
  input wire logic soft_reset_active,
  input wire logic bus_synchronized,
  input wire logic bus_off_state
);
  // ====
  // one clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_rdata_idle:
  assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_unmapped_zero:
  assert property (reg_read && reg_addr > OFS_RX_ENABLES
    |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_soft_irq_quiet:
  assert property (soft_reset_active [*3]
    |-> !(wakeup_irq || error_irq || receive_irq))
    else $error("interrupt during soft reset");
  a_sync_lost:
  assert property (soft_reset_active [*2] |-> !bus_synchronized)
    else $error("synchronised during soft reset");
  a_exch_cause:
  assert property (buffer_exchange |-> $past(rx_message_ok))
    else $error("exchange without message");
  a_full_no_exch:
  assert property (receive_irq && rx_message_ok && !$past(reg_write)
    |=> !buffer_exchange) else $error("exchange into full buffer");
  a_busoff_cause:
  assert property ($rose(bus_off_state)
    |-> $past(transmit_error_count) > COUNT_MAX
    || $past(transmit_error_count, 2) > COUNT_MAX)
    else $error("bus-off without count over limit");
  a_wakeup_cause:
  assert property ($rose(wakeup_irq) |-> $past(sleep_mode, 2))
    else $error("wakeup while awake");
endmodule : can_bit_timing_rx_flags_checker
`default_nettype wire

// ===== test/tb_can_bit_timing_rx_flags.sv
// self-checking bench for the bit timing and receiver flag block
`timescale 1ns/1ns
`default_nettype none

module tb_can_bit_timing_rx_flags
  import can_timing_pkg::*;
();
  // ====
  // stimulus and observed signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep_mode = 1'b0;
  logic [7:0] receive_error_count = 8'h00;
  logic [8:0] transmit_error_count = 9'h000;
  logic rx_overrun = 1'b0;
  logic rx_message_ok = 1'b0;
  logic start = 1'b0;
  logic [7:0] dom_len = 8'h14;
  wire logic can_rx;
  logic buffer_exchange, wakeup_irq, error_irq, receive_irq;
  logic soft_reset_active, bus_synchronized, bus_off_state;
  logic [7:0] rd_data;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;

  // ====
  // register rows: write flag, index, data, expected read
  typedef struct packed {
    logic w;
    logic [2:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } row_s;
  localparam row_s ROWS [15] = '{
    '{1'b0, 3'h0, 8'h00, 8'h01}, '{1'b0, 3'h1, 8'h00, 8'h00},
    '{1'b0, 3'h2, 8'h00, 8'h00}, '{1'b0, 3'h3, 8'h00, 8'h00},
    '{1'b0, 3'h4, 8'h00, 8'h00}, '{1'b0, 3'h5, 8'h00, 8'h00},
    '{1'b0, 3'h6, 8'h00, 8'h00}, '{1'b0, 3'h7, 8'h00, 8'h00},
    '{1'b1, 3'h2, 8'hc0, 8'hc0}, '{1'b1, 3'h2, 8'h80, 8'h80},
    '{1'b1, 3'h2, 8'h40, 8'h40}, '{1'b1, 3'h2, 8'h3f, 8'h3f},
    '{1'b1, 3'h2, 8'h00, 8'h00},
    '{1'b1, 3'h3, 8'hff, 8'hff},
    '{1'b1, 3'h3, 8'h23, 8'h23}};
  // error count rows: rx count, tx count, clear mask, expected flags
  typedef struct packed {
    logic [7:0] r;
    logic [8:0] t;
    logic [7:0] m;
    logic [7:0] e;
  } err_s;
  localparam err_s ERRS [7] = '{
    '{8'h60, 9'h000, 8'h00, 8'h40}, '{8'h7f, 9'h000, 8'h10, 8'h50},
    '{8'h00, 9'h000, 8'h50, 8'h00}, '{8'h00, 9'h060, 8'h00, 8'h20},
    '{8'h00, 9'h080, 8'h00, 8'h28}, '{8'h00, 9'h100, 8'h00, 8'h2c},
    '{8'h00, 9'h000, 8'hff, 8'h04}};

  always #5 clk = ~clk;

  can_bit_timing_rx_flags i_can_bit_timing_rx_flags (.clk, .rst,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .can_rx,
    .sleep_mode, .receive_error_count, .transmit_error_count, .rx_overrun,
    .rx_message_ok, .buffer_exchange, .wakeup_irq, .error_irq,
    .receive_irq, .soft_reset_active, .bus_synchronized, .bus_off_state);
  can_bus_node i_can_bus_node (.clk, .start, .dom_len, .can_rx);

  // ====
  // bus tasks and comparison
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // read data stand only in the cycle after the strobe
  task automatic rc(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask : rc
  task automatic msg_ok(input logic e);
    @(posedge clk);
    rx_message_ok <= 1'b1;
    @(posedge clk);
    rx_message_ok <= 1'b0;
    #1 chk({7'h00, buffer_exchange}, {7'h00, e});
  endtask : msg_ok
  task automatic close_out;
    $display("fail_count %0d tests_run %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // hang guard, well above the bus-off recovery wait
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      close_out();
    end
  end

  // ====
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    foreach (ROWS[i])
    begin
      if (ROWS[i].w)
        wr(ROWS[i].a, ROWS[i].d);
      rc(ROWS[i].a, ROWS[i].e);
    end
    // eight-quantum bits of one clock each: 11 bits to sync
    wr(OFS_FIRST_CTRL, 8'h00);
    n = 0;
    while (bus_synchronized !== 1'b1 && n < 400)
    begin
      @(posedge clk);
      n++;
    end
    chk(8'(n >= 80 && n <= 110), 8'h01);
    wr(OFS_JUMP_PRESCALE, 8'h3f);
    wr(OFS_SEG_SAMPLING, 8'hff);
    wr(OFS_SECOND_CTRL, 8'h07);
    rc(OFS_JUMP_PRESCALE, 8'h00);
    rc(OFS_SEG_SAMPLING, 8'h23);
    rc(OFS_SECOND_CTRL, 8'h00);
    rc(OFS_FIRST_CTRL, 8'h10);
    wr(OFS_RX_ENABLES, 8'hff);
    rc(OFS_RX_ENABLES, 8'hff);
    // second message on a full buffer is refused and overruns
    msg_ok(1'b1);
    rc(OFS_RX_FLAGS, 8'h01);
    chk({7'h00, receive_irq}, 8'h01);
    msg_ok(1'b0);
    rc(OFS_RX_FLAGS, 8'h03);
    chk({7'h00, error_irq}, 8'h01);
    wr(OFS_RX_FLAGS, 8'h00);
    rc(OFS_RX_FLAGS, 8'h03);
    wr(OFS_RX_FLAGS, 8'h01);
    rc(OFS_RX_FLAGS, 8'h02);
    wr(OFS_RX_FLAGS, 8'h02);
    rc(OFS_RX_FLAGS, 8'h00);
    // plain overrun event
    @(posedge clk) rx_overrun <= 1'b1;
    @(posedge clk) rx_overrun <= 1'b0;
    rc(OFS_RX_FLAGS, 8'h02);
    wr(OFS_RX_FLAGS, 8'h02);
    rc(OFS_RX_FLAGS, 8'h00);
    // dominant burst while asleep
    @(posedge clk) sleep_mode <= 1'b1;
    @(posedge clk) start <= 1'b1;
    @(posedge clk) start <= 1'b0;
    repeat (12) @(posedge clk);
    rc(OFS_RX_FLAGS, 8'h80);
    chk({7'h00, wakeup_irq}, 8'h01);
    sleep_mode <= 1'b0;
    wr(OFS_RX_FLAGS, 8'h80);
    rc(OFS_RX_FLAGS, 8'h00);
    foreach (ERRS[i])
    begin
      receive_error_count <= ERRS[i].r;
      transmit_error_count <= ERRS[i].t;
      repeat (3) @(posedge clk);
      if (ERRS[i].m != 8'h00)
        wr(OFS_RX_FLAGS, ERRS[i].m);
      rc(OFS_RX_FLAGS, ERRS[i].e);
    end
    chk({7'h00, bus_off_state}, 8'h01);
    // recovery takes 128 runs of 11 recessive eight-clock bits
    n = 0;
    while (bus_off_state !== 1'b0 && n < 20000)
    begin
      @(posedge clk);
      n++;
    end
    chk(8'(n >= 11000 && n <= 12500), 8'h01);
    wr(OFS_RX_FLAGS, 8'h04);
    rc(OFS_RX_FLAGS, 8'h00);
    // soft reset wipes and holds flags and enables
    msg_ok(1'b1);
    wr(OFS_FIRST_CTRL, 8'h01);
    wr(OFS_RX_FLAGS, 8'hff);
    repeat (3) @(posedge clk);
    rc(OFS_RX_FLAGS, 8'h00);
    rc(OFS_RX_ENABLES, 8'h00);
    chk({7'h00, receive_irq}, 8'h00);
    chk({7'h00, bus_synchronized}, 8'h00);
    // hard reset in mid-run
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(OFS_SEG_SAMPLING, 8'h00);
    rc(OFS_FIRST_CTRL, 8'h01);
    close_out();
  end
endmodule : tb_can_bit_timing_rx_flags

bind can_bit_timing_rx_flags can_bit_timing_rx_flags_checker i_chk (.clk,
  .rst, .reg_addr, .reg_write, .reg_read, .reg_rdata, .sleep_mode,
  .transmit_error_count, .rx_message_ok, .buffer_exchange, .wakeup_irq,
  .error_irq, .receive_irq, .soft_reset_active, .bus_synchronized,
  .bus_off_state);
`default_nettype wire
